// ### clutch_pkg.sv
package clutch_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [5:0] OFS_CTRL     = 6'h00;
    localparam logic [5:0] OFS_MODE     = 6'h04;
    localparam logic [5:0] OFS_ON_ADDR  = 6'h08;
    localparam logic [5:0] OFS_OFF_ADDR = 6'h0C;
    localparam logic [5:0] OFS_SLIP     = 6'h10;
    localparam logic [5:0] OFS_INPOS    = 6'h14;
    localparam logic [5:0] OFS_TCONST   = 6'h18;
    localparam logic [5:0] OFS_STATUS   = 6'h1C;
    localparam logic [5:0] OFS_OUT      = 6'h20;

    // ==========================================================
    // Field positions
    localparam int CTRL_CMD_BIT    = 0;
    localparam int CTRL_METH_LSB   = 1;
    localparam int CTRL_EXT_BIT    = 3;
    localparam int CTRL_REV_BIT    = 4;
    localparam int ST_ENGAGED_BIT  = 0;
    localparam int ST_DONE_BIT     = 1;
    localparam int ST_MODE_ERR_BIT = 2;
    localparam int ST_OS_BUSY_BIT  = 3;

    // ==========================================================
    // Reset values and limits
    localparam logic [2:0]  MODE_MAX        = 3'h4;
    localparam logic [31:0] SLIP_RESET      = 32'h0000_1000;
    localparam logic [31:0] INPOS_RESET     = 32'h0000_0010;
    localparam logic [4:0]  TCONST_RESET    = 5'h03;
    localparam int          LIN_STEP_SHIFT  = 4;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 100;
    // Plain default; set to the system's operation cycle
    localparam int OP_CYCLE_NS     = 1000000;
    localparam int OP_CYCLE_CLKS   = OP_CYCLE_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Enumerations
    typedef enum logic [2:0] {
        MODE_ONOFF, MODE_ADDR, MODE_ADDR_ALT, MODE_ONESHOT, MODE_ONESHOT_OFF
    } clutch_mode_e;

    typedef enum logic [1:0] {
        METH_DIRECT, METH_TCONST, METH_EXP, METH_LINEAR
    } smooth_meth_e;

endpackage

// ### virtual_clutch.sv
// Operation
// - Engaged passes all travel, disengaged none
// - Time-constant method uses fixed time constant
// - Time-constant restarts smoothing on input change
// - Slippage methods pass later changes directly
// - Slippage amount constant regardless of speed
// - Linear method ramps total slip to setting
// - Done flag clears on start, sets in-position
// - Mode above 4 flagged, old mode kept
// - Mode change accepted any time
// - On/off mode follows clutch command
// - On/off reaches state within one cycle
// - Status shows engagement, refreshed every cycle
// - Address mode engages at engage address
// - Address mode disengages at disengage address
// - Address ignored when command disagrees
// - Compare axis or within-revolution value
// - Addresses signed 32-bit, applied immediately
// - Alternating mode toggles at both addresses
// - Alternating mode suspends while command low
// - External input only with incremental encoder
// - One-shot uses pre and post travel
// - Direct clutch switches with no smoothing
`timescale 1ns/10ps
`default_nettype none
module virtual_clutch
    import clutch_pkg::*;
#(
    parameter int OP_CLKS = OP_CYCLE_CLKS
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset,
    // Avalon-MM slave
    input  wire logic [5:0]         address,
    input  wire logic               read,
    input  wire logic               write,
    input  wire logic [31:0]        writedata,
    output logic      [31:0]        readdata,
    output logic                    waitrequest,
    // Drive side
    input  wire logic signed [31:0] drive_travel,
    input  wire logic signed [31:0] drive_position,
    input  wire logic signed [31:0] drive_position_rev,
    input  wire logic               drive_is_incr_encoder,
    input  wire logic               encoder_start_input,
    // Output axis side
    output logic signed [31:0]      out_travel,
    output logic                    out_valid,
    output logic                    clutch_status,
    output logic                    smooth_done
);
    import clutch_pkg::*;

    typedef enum logic [1:0] {OS_IDLE, OS_PRE, OS_POST} oneshot_e;

    // ==========================================================
    // Registers and state
    logic               command;
    smooth_meth_e       method;
    logic               ext_enable;
    logic               use_rev;
    clutch_mode_e       mode;
    logic               mode_error;
    logic signed [31:0] on_addr;
    logic signed [31:0] off_addr;
    logic        [31:0] slip;
    logic        [31:0] inpos;
    logic        [4:0]  tconst;
    logic               engaged;
    logic               smoothing;
    logic        [31:0] remain;
    logic        [31:0] lin_step;
    logic signed [31:0] filt;
    logic signed [31:0] prev_target;
    logic signed [31:0] prev_pos;
    logic               prev_cmd;
    oneshot_e           os_state;
    logic signed [31:0] os_acc;
    logic signed [31:0] os_pre;
    logic signed [31:0] os_post;
    logic [31:0]        div_cnt;
    logic               op_tick;
    logic [2:0]         enc_sync;
    logic               enc_level;

    wire logic accept_wr = write && !waitrequest;
    wire logic accept_rd = read && waitrequest;

    // ==========================================================
    // Operation cycle divider
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_cnt <= 32'h0000_0000;
            op_tick <= 1'b0;
        end else if (div_cnt >= 32'(OP_CLKS - 1)) begin
            div_cnt <= 32'h0000_0000;
            op_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 32'h0000_0001;
            op_tick <= 1'b0;
        end
    end

    // ==========================================================
    // Encoder start pin synchroniser
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            enc_sync  <= 3'h0;
            enc_level <= 1'b0;
        end else begin
            enc_sync <= {enc_sync[1:0], encoder_start_input};
            if (enc_sync[1] == enc_sync[2]) begin
                enc_level <= enc_sync[2];
            end
        end
    end

    // ==========================================================
    // Bus slave: one wait state on every access
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (accept_rd) begin
            unique case (address & 6'h3C)
                OFS_CTRL:     readdata <= {27'h0, use_rev, ext_enable, method, command};
                OFS_MODE:     readdata <= {29'h0, mode};
                OFS_ON_ADDR:  readdata <= on_addr;
                OFS_OFF_ADDR: readdata <= off_addr;
                OFS_SLIP:     readdata <= slip;
                OFS_INPOS:    readdata <= inpos;
                OFS_TCONST:   readdata <= {27'h0, tconst};
                OFS_STATUS:   readdata <= {28'h0, os_state != OS_IDLE, mode_error, smooth_done, clutch_status};
                OFS_OUT:      readdata <= out_travel;
                default:      readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            command    <= 1'b0;
            method     <= METH_DIRECT;
            ext_enable <= 1'b0;
            use_rev    <= 1'b0;
            on_addr    <= 32'sh0000_0000;
            off_addr   <= 32'sh0000_0000;
            slip       <= SLIP_RESET;
            inpos      <= INPOS_RESET;
            tconst     <= TCONST_RESET;
        end else if (accept_wr) begin
            unique case (address & 6'h3C)
                OFS_CTRL: begin
                    command    <= writedata[CTRL_CMD_BIT];
                    method     <= smooth_meth_e'(writedata[CTRL_METH_LSB +: 2]);
                    ext_enable <= writedata[CTRL_EXT_BIT];
                    use_rev    <= writedata[CTRL_REV_BIT];
                end
                OFS_ON_ADDR:  on_addr  <= writedata;
                OFS_OFF_ADDR: off_addr <= writedata;
                OFS_SLIP:     slip     <= writedata;
                OFS_INPOS:    inpos    <= writedata;
                OFS_TCONST:   tconst   <= writedata[4:0];
                default: begin
                end
            endcase
        end
    end

    // Illegal mode keeps the last good one
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode       <= MODE_ONOFF;
            mode_error <= 1'b0;
        end else if (accept_wr && (address & 6'h3C) == OFS_MODE) begin
            if (writedata > 32'(MODE_MAX)) begin
                mode_error <= 1'b1;
            end else begin
                mode       <= clutch_mode_e'(writedata[2:0]);
                mode_error <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Engagement decision
    function automatic logic reached(input logic signed [31:0] p0, input logic signed [31:0] p1,
                                     input logic signed [31:0] a);
        reached = (p1 == a) || (p0 < a && p1 > a) || (p0 > a && p1 < a);
    endfunction

    logic signed [31:0] pos;
    logic signed [31:0] os_acc_new;
    logic               next_engaged;
    oneshot_e           next_os_state;

    always_comb begin
        pos           = use_rev ? drive_position_rev : drive_position;
        os_acc_new    = os_acc + drive_travel;
        next_engaged  = engaged;
        next_os_state = os_state;
        unique case (mode)
            MODE_ONOFF: begin
                if (ext_enable && drive_is_incr_encoder) begin
                    next_engaged = command && enc_level;
                end else begin
                    next_engaged = command;
                end
            end
            MODE_ADDR: begin
                if (command && reached(prev_pos, pos, on_addr)) begin
                    next_engaged = 1'b1;
                end else if (!command && reached(prev_pos, pos, off_addr)) begin
                    next_engaged = 1'b0;
                end
            end
            MODE_ADDR_ALT: begin
                if (!command) begin
                    next_engaged = 1'b0;
                end else if (!engaged && reached(prev_pos, pos, on_addr)) begin
                    next_engaged = 1'b1;
                end else if (engaged && reached(prev_pos, pos, off_addr)) begin
                    next_engaged = 1'b0;
                end
            end
            MODE_ONESHOT, MODE_ONESHOT_OFF: begin
                if (os_state == OS_IDLE) begin
                    next_engaged = 1'b0;
                end
                unique case (os_state)
                    OS_IDLE: begin
                        if (mode == MODE_ONESHOT && command && !prev_cmd) begin
                            next_os_state = OS_PRE;
                            if (off_addr == 32'sh0) begin
                                next_engaged  = 1'b1;
                                next_os_state = OS_POST;
                            end
                        end
                    end
                    OS_PRE: begin
                        if (reached(os_acc, os_acc_new, os_pre)) begin
                            next_engaged  = 1'b1;
                            next_os_state = OS_POST;
                        end
                    end
                    OS_POST: begin
                        if (reached(os_acc, os_acc_new, os_post)) begin
                            next_engaged  = 1'b0;
                            next_os_state = OS_IDLE;
                        end
                    end
                endcase
            end
            default: next_engaged = engaged;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            engaged  <= 1'b0;
            prev_pos <= 32'sh0000_0000;
            prev_cmd <= 1'b0;
            os_state <= OS_IDLE;
            os_acc   <= 32'sh0000_0000;
            os_pre   <= 32'sh0000_0000;
            os_post  <= 32'sh0000_0000;
        end else if (op_tick) begin
            engaged  <= next_engaged;
            prev_pos <= pos;
            prev_cmd <= command;
            os_state <= next_os_state;
            if (os_state == OS_IDLE || next_os_state != os_state) begin
                os_acc <= 32'sh0000_0000;
            end else begin
                os_acc <= os_acc_new;
            end
            if (os_state == OS_IDLE) begin
                // Setting changes apply from the next rising command
                os_pre  <= off_addr;
                os_post <= on_addr;
            end
        end
    end

    // ==========================================================
    // Smoothing
    logic               start_evt;
    logic signed [31:0] target;
    logic        [31:0] mag;
    logic        [31:0] part;
    logic        [31:0] step;
    logic        [31:0] rem_now;
    logic        [31:0] next_remain;
    logic signed [31:0] diff;
    logic signed [31:0] next_filt;
    logic signed [31:0] next_out;
    logic        [31:0] err;

    always_comb begin
        start_evt   = next_engaged != engaged;
        target      = next_engaged ? drive_travel : 32'sh0000_0000;
        mag         = drive_travel[31] ? 32'(-drive_travel) : 32'(drive_travel);
        rem_now     = start_evt ? slip : remain;
        step        = (method == METH_EXP) ? ((rem_now + 32'h1) >> 1) : lin_step;
        if (method == METH_LINEAR && start_evt) begin
            step = (slip >> LIN_STEP_SHIFT) + 32'h1;
        end
        part        = (step < mag) ? step : mag;
        part        = (part < rem_now) ? part : rem_now;
        next_remain = rem_now - part;
        diff        = target - filt;
        next_filt   = filt + (diff >>> tconst);
        if ((diff >>> tconst) == 32'sh0) begin
            next_filt = target;
        end
        err         = diff[31] ? 32'(-diff) : 32'(diff);
        next_out    = target;
        unique case (method)
            METH_DIRECT: next_out = target;
            METH_TCONST: next_out = next_filt;
            METH_EXP, METH_LINEAR: begin
                if (smoothing || start_evt) begin
                    if (next_engaged) begin
                        next_out = drive_travel[31] ? 32'(-(mag - part)) : 32'(mag - part);
                    end else begin
                        next_out = drive_travel[31] ? 32'(-part) : 32'(part);
                    end
                end else begin
                    next_out = target;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            out_travel    <= 32'sh0000_0000;
            out_valid     <= 1'b0;
            clutch_status <= 1'b0;
            filt          <= 32'sh0000_0000;
            prev_target   <= 32'sh0000_0000;
        end else begin
            out_valid <= op_tick;
            if (op_tick) begin
                out_travel    <= next_out;
                clutch_status <= next_engaged;
                filt          <= next_filt;
                prev_target   <= target;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            smoothing   <= 1'b0;
            remain      <= 32'h0000_0000;
            lin_step    <= 32'h0000_0001;
            smooth_done <= 1'b1;
        end else if (op_tick) begin
            if (method == METH_TCONST) begin
                smoothing <= 1'b0;
                if (start_evt || (smooth_done && target != prev_target)) begin
                    smooth_done <= 1'b0;
                end else begin
                    smooth_done <= (err < inpos);
                end
            end else if (method == METH_DIRECT) begin
                smoothing   <= 1'b0;
                smooth_done <= 1'b1;
            end else begin
                remain <= next_remain;
                if (start_evt) begin
                    lin_step  <= step;
                    smoothing <= 1'b1;
                end else if (next_remain < inpos) begin
                    smoothing <= 1'b0;
                end
                if (start_evt) begin
                    smooth_done <= 1'b0;
                end else if (next_remain < inpos) begin
                    smooth_done <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Assertions
    a_mode_reject: assert property (@(posedge ref_clk) disable iff (reset)
        (accept_wr && (address & 6'h3C) == OFS_MODE && writedata > 32'h4)
        |=> (mode_error && mode == $past(mode)))
        else $error("Illegal mode not rejected");

    a_onoff_follow: assert property (@(posedge ref_clk) disable iff (reset)
        (op_tick && mode == MODE_ONOFF && !ext_enable) |=> (clutch_status == $past(command)))
        else $error("On/off mode did not follow command");

    a_direct_pass: assert property (@(posedge ref_clk) disable iff (reset)
        (op_tick && method == METH_DIRECT && !start_evt)
        |=> (out_travel == (clutch_status ? $past(drive_travel) : 32'sh0)))
        else $error("Direct clutch output wrong");

    a_addr_hold: assert property (@(posedge ref_clk) disable iff (reset)
        (op_tick && mode == MODE_ADDR && command && engaged) |=> engaged)
        else $error("Address mode dropped while commanded");

    a_alt_suspend: assert property (@(posedge ref_clk) disable iff (reset)
        (op_tick && mode == MODE_ADDR_ALT && !command) |=> (!engaged && !clutch_status))
        else $error("Alternating mode not suspended");

    a_done_clear: assert property (@(posedge ref_clk) disable iff (reset)
        (op_tick && start_evt && method != METH_DIRECT) |=> !smooth_done)
        else $error("Done flag not cleared on start");

    a_status_cycle: assert property (@(posedge ref_clk) disable iff (reset)
        $changed(clutch_status) |-> $past(op_tick))
        else $error("Status changed off the operation cycle");

    a_addr_apply: assert property (@(posedge ref_clk) disable iff (reset)
        (accept_wr && (address & 6'h3C) == OFS_ON_ADDR) |=> (on_addr == $past(writedata)))
        else $error("Engage address not applied");

    a_wait_one: assert property (@(posedge ref_clk) disable iff (reset)
        ((read || write) && waitrequest) |=> !waitrequest)
        else $error("Bus answer late");

    c_addr_engage: cover property (@(posedge ref_clk) disable iff (reset)
        op_tick && mode == MODE_ADDR && start_evt && next_engaged);
    c_exp_done: cover property (@(posedge ref_clk) disable iff (reset)
        method == METH_EXP && !smooth_done ##[1:1000] smooth_done);
    c_oneshot_end: cover property (@(posedge ref_clk) disable iff (reset)
        os_state == OS_POST ##1 os_state == OS_IDLE);

endmodule
`default_nettype wire

// ### drive_axis_model.sv
`timescale 1ns/10ps
`default_nettype none
module drive_axis_model (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset,
    // Speed chosen by the bench
    input  wire logic signed [31:0] speed,
    // Clutch side
    input  wire logic               out_valid,
    input  wire logic signed [31:0] out_travel,
    output logic signed [31:0]      drive_travel,
    output logic signed [31:0]      drive_position,
    output logic signed [31:0]      drive_position_rev,
    output logic signed [31:0]      out_sum
);
    // ==========================================================
    // Drive axis: advances once per operation cycle
    // Bench keeps speed well under the slip setting
    assign drive_travel       = speed;
    assign drive_position_rev = drive_position & 32'h0000_0FFF;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            drive_position <= 32'h0;
        end else if (out_valid) begin
            drive_position <= drive_position + speed;
        end
    end
    // ==========================================================
    // Output axis: sums what the clutch hands on
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            out_sum <= 32'h0;
        end else if (out_valid) begin
            out_sum <= out_sum + out_travel;
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    import clutch_pkg::*;
    logic               ref_clk = 0, reset = 1, read = 0, write = 0, waitrequest, out_valid, clutch_status, smooth_done;
    logic        [5:0]  address = 6'h00;
    logic        [31:0] writedata = 32'h0, readdata, rd;
    logic signed [31:0] speed = 32'h0000_000A, travel, pos, pos_rev, out_travel, out_sum, p0, s0;
    logic               enc_ok = 1'b0, enc_pin = 1'b0;
    int                 err_count = 0, n_checks = 0, cyc = 0;
    typedef struct { logic cmd; logic st; } row_s;
    row_s rows[5] = '{'{1'b1, 1'b1}, '{1'b0, 1'b0}, '{1'b1, 1'b1}, '{1'b1, 1'b1}, '{1'b0, 1'b0}};

    virtual_clutch #(.OP_CLKS(8)) uut (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .drive_travel(travel), .drive_position(pos), .drive_position_rev(pos_rev),
        .drive_is_incr_encoder(enc_ok), .encoder_start_input(enc_pin), .out_travel(out_travel),
        .out_valid(out_valid), .clutch_status(clutch_status), .smooth_done(smooth_done));
    drive_axis_model axis (.ref_clk(ref_clk), .reset(reset), .speed(speed), .out_valid(out_valid),
        .out_travel(out_travel), .drive_travel(travel), .drive_position(pos),
        .drive_position_rev(pos_rev), .out_sum(out_sum));

    always #50 ref_clk = ~ref_clk;
    // ==========================================================
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Avalon master; leading edge keeps strobes from changing twice at once
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic op_wait(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin @(posedge ref_clk); k++; end while (out_valid !== 1'b1 && k < 50);
        end
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        `CHK(clutch_status, 1'b0)
        `CHK(smooth_done, 1'b1)
        bus(0, OFS_SLIP, 0);   `CHK(rd, SLIP_RESET)
        bus(0, OFS_INPOS, 0);  `CHK(rd, INPOS_RESET)
        bus(0, OFS_TCONST, 0); `CHK(rd[4:0], TCONST_RESET)
        bus(0, 6'h24, 0);      `CHK(rd, 32'h0)
        // On/off rows, direct method
        foreach (rows[i]) begin
            bus(1, OFS_CTRL, {31'h0, rows[i].cmd});
            op_wait(2);
            `CHK(clutch_status, rows[i].st)
            `CHK(out_travel, rows[i].st ? speed : 32'sh0)
            bus(0, OFS_STATUS, 0); `CHK(rd[ST_ENGAGED_BIT], rows[i].st)
        end
        // Address mode: engage address passes with command low
        bus(1, OFS_MODE, 32'h1);
        bus(1, OFS_ON_ADDR, pos + 32'sd25);
        op_wait(5);
        `CHK(clutch_status, 1'b0)
        bus(1, OFS_ON_ADDR, pos + 32'sd25);
        bus(1, OFS_CTRL, 32'h1);
        op_wait(1);
        `CHK(clutch_status, 1'b0)
        op_wait(5);
        `CHK(clutch_status, 1'b1)
        bus(1, OFS_OFF_ADDR, pos + 32'sd25);
        op_wait(5);
        `CHK(clutch_status, 1'b1)
        bus(1, OFS_CTRL, 32'h0);
        bus(1, OFS_OFF_ADDR, pos + 32'sd35);
        op_wait(1);
        `CHK(clutch_status, 1'b1)
        op_wait(6);
        `CHK(clutch_status, 1'b0)
        // Out-of-range mode is flagged and ignored
        bus(1, OFS_MODE, 32'h5);
        bus(0, OFS_STATUS, 0); `CHK(rd[ST_MODE_ERR_BIT], 1'b1)
        bus(0, OFS_MODE, 0);   `CHK(rd[2:0], 3'h1)
        // Alternating mode toggles while command held
        bus(1, OFS_MODE, 32'h2);
        bus(1, OFS_ON_ADDR, pos + 32'sd25);
        bus(1, OFS_OFF_ADDR, pos + 32'sd75);
        bus(1, OFS_CTRL, 32'h1);
        op_wait(5);
        `CHK(clutch_status, 1'b1)
        op_wait(6);
        `CHK(clutch_status, 1'b0)
        bus(1, OFS_ON_ADDR, pos + 32'sd25);
        bus(1, OFS_CTRL, 32'h0);
        op_wait(6);
        `CHK(clutch_status, 1'b0)
        // Slippage methods; travel stopped around each switch
        speed <= 32'sh0;
        bus(1, OFS_MODE, 32'h0);
        bus(1, OFS_SLIP, 32'h0000_0064);
        bus(1, OFS_INPOS, 32'h1);
        bus(1, OFS_CTRL, 32'h5);
        op_wait(2);
        `CHK(smooth_done, 1'b0)
        p0 = pos;
        s0 = out_sum;
        speed <= 32'sh0000_000A;
        op_wait(20);
        speed <= 32'sh0;
        op_wait(2);
        `CHK((pos - p0) - (out_sum - s0), 32'h0000_0064)
        `CHK(smooth_done, 1'b1)
        s0 = out_sum;
        bus(1, OFS_CTRL, 32'h6);
        op_wait(2);
        speed <= 32'sh0000_000A;
        op_wait(25);
        speed <= 32'sh0;
        op_wait(2);
        `CHK(out_sum - s0, 32'h0000_0064)
        // Time-constant method
        bus(1, OFS_CTRL, 32'h3);
        op_wait(3);
        speed <= 32'sh0000_000A;
        op_wait(1);
        `CHK(out_travel > 0 && out_travel < speed, 1'b1)
        `CHK(smooth_done, 1'b0)
        op_wait(6);
        `CHK(out_travel, speed)
        `CHK(smooth_done, 1'b1)
        // External input gating
        enc_ok <= 1'b1;
        bus(1, OFS_CTRL, 32'h9);
        op_wait(2);
        `CHK(clutch_status, 1'b0)
        enc_pin <= 1'b1;
        op_wait(2);
        `CHK(clutch_status, 1'b1)
        // One-shot: 20 before engage, 30 after
        bus(1, OFS_CTRL, 32'h0);
        bus(1, OFS_OFF_ADDR, 32'h14);
        bus(1, OFS_ON_ADDR, 32'h1E);
        bus(1, OFS_MODE, 32'h3);
        op_wait(1);
        bus(1, OFS_CTRL, 32'h1);
        op_wait(2);
        `CHK(clutch_status, 1'b0)
        op_wait(2);
        `CHK(clutch_status, 1'b1)
        op_wait(4);
        `CHK(clutch_status, 1'b0)
        // Reset in mid-run
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        `CHK({waitrequest, out_valid, smooth_done}, 3'h5)
        bus(0, OFS_MODE, 0);
        `CHK(rd[2:0], 3'h0)
        bus(0, OFS_SLIP, 0);
        `CHK(rd, SLIP_RESET)
        wrap_up();
    end
endmodule
`default_nettype wire
